// >>> src/bidir_port_with_overrides.sv
// Two bidirectional ports with peripheral overrides and an Avalon-MM register slave
//
// Summary of operation
// RL1 - A second port direction bit of 1 puts that pin driver in high impedance.
// RL2 - A second port direction bit of 0 drives that pin from its latch bit.
// RL3 - The second port latch reads and writes back the latched value, not pins.
// RL4 - Reset makes every second port pin a digital input.
// RL5 - Third port direction bit 4 turns the second port into a TTL slave port.
// RL6 - Dual or quad PWM output modes switch the parallel slave port off.
// RL7 - Three second port pins may carry enhanced PWM outputs B, C and D.
// RL8 - With direction bit 4 set, pin 4 feeds the serial module SPI data input.
// RL9 - In I2C mode serial data drives pin 4 and pin 4 feeds I2C data input.
// RL10 - With direction bit 5 clear, SPI data output drives pin 5 over the latch.
// RL11 - USART async transmit drives pin 6 over port data; software sets output.
// RL12 - Sync master clock drives pin 6; in sync slave pin 6 is the clock input.
// RL13 - With direction bit 7 set, pin 7 feeds the USART receive input.
// RL14 - Sync transmit drives pin 7; for sync receive pin 7 feeds USART data in.
// RL15 - Don't-care functions ignore or override the direction bit.
// RL16 - Pin select bit puts capture unit two on pin 1, else port B bit 3.
// RL17 - The first port has an 8-bit latch register read and written as stored.
// RL18 - Direction reads return stored bits even while a peripheral overrides.
// RL19 - Port data reads return pin levels; writes update that port's latch.
//
// Added by the designer: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module bidir_port_with_overrides
  import dual_port_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [dual_port_pkg::ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [3:0] avsByteenable,
  input wire logic [dual_port_pkg::DATA_W-1:0] avsWritedata,
  output logic [dual_port_pkg::DATA_W-1:0] avsReaddata,
  output logic avsWaitrequest,
  // Peripheral side
  input wire dual_port_pkg::periph_req_t periphReq,
  output dual_port_pkg::periph_ret_t periphRet,
  // First port pins
  input wire logic [dual_port_pkg::PORT_W-1:0] portCIn,
  output logic [dual_port_pkg::PORT_W-1:0] portCOut,
  output logic [dual_port_pkg::PORT_W-1:0] portCOe,
  // Second port pins
  input wire logic [dual_port_pkg::PORT_W-1:0] portDIn,
  output logic [dual_port_pkg::PORT_W-1:0] portDOut,
  output logic [dual_port_pkg::PORT_W-1:0] portDOe,
  // Alternate capture unit two pin on port B bit 3
  input wire logic altPortBBit3In,
  output logic altPortBBit3Out,
  output logic altPortBBit3Oe
);
  import dual_port_pkg::*;

  // Register state
  logic [7:0] latchC, next_latchC;
  logic [7:0] dirC, next_dirC;
  logic [7:0] latchD, next_latchD;
  logic [7:0] dirD, next_dirD;
  logic [7:0] dirE, next_dirE;
  logic [7:0] config_, next_config_;
  logic ack, next_ack;
  logic [DATA_W-1:0] rdata, next_rdata;

  // Pin synchronisers
  logic [7:0] cMeta, cSync, dMeta, dSync;
  logic bMeta, bSync;

  logic req;
  logic wrTake;
  logic [7:0] wrByte;
  logic [7:0] cOut, cOe, dOut, dOe;
  logic capOnC;
  logic parallelActive;
  logic pwmMulti;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cMeta <= 8'h00;
      cSync <= 8'h00;
      dMeta <= 8'h00;
      dSync <= 8'h00;
      bMeta <= 1'b0;
      bSync <= 1'b0;
    end else begin
      cMeta <= portCIn;
      cSync <= cMeta;
      dMeta <= portDIn;
      dSync <= dMeta;
      bMeta <= altPortBBit3In;
      bSync <= bMeta;
    end
  end

  // Bus handshake: one wait cycle, then the answer; writes land on the answering edge
  assign req = avsRead | avsWrite;
  assign avsWaitrequest = req & ~ack;
  assign wrTake = avsWrite & ack & avsByteenable[0];
  assign wrByte = avsWritedata[7:0];
  assign avsReaddata = rdata;

  always_comb begin
    next_ack = req & ~ack;
    next_rdata = rdata;
    if (avsRead & ~ack) begin
      next_rdata = '0;
      case (avsAddress)
        OFS_C_PINS: next_rdata[7:0] = cSync; // RL19
        OFS_C_LATCH: next_rdata[7:0] = latchC; // RL17
        OFS_C_DIR: next_rdata[7:0] = dirC; // RL18
        OFS_D_PINS: next_rdata[7:0] = dSync; // RL19
        OFS_D_LATCH: next_rdata[7:0] = latchD; // RL3
        OFS_D_DIR: next_rdata[7:0] = dirD; // RL18
        OFS_E_DIR: next_rdata[7:0] = dirE;
        OFS_CONFIG: next_rdata[7:0] = config_;
        default: next_rdata = '0;
      endcase
    end
  end

  always_comb begin
    next_latchC = latchC;
    next_dirC = dirC;
    next_latchD = latchD;
    next_dirD = dirD;
    next_dirE = dirE;
    next_config_ = config_;
    if (wrTake) begin
      case (avsAddress)
        OFS_C_PINS: next_latchC = wrByte; // RL19
        OFS_C_LATCH: next_latchC = wrByte; // RL17
        OFS_C_DIR: next_dirC = wrByte;
        OFS_D_PINS: next_latchD = wrByte; // RL19
        OFS_D_LATCH: next_latchD = wrByte; // RL3
        OFS_D_DIR: next_dirD = wrByte;
        OFS_E_DIR: next_dirE = wrByte;
        OFS_CONFIG: next_config_ = wrByte;
        default: next_config_ = config_;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      latchC <= RST_LATCH;
      dirC <= RST_DIR;
      latchD <= RST_LATCH;
      dirD <= RST_DIR; // RL4
      dirE <= RST_E_DIR;
      config_ <= RST_CONFIG;
      ack <= 1'b0;
      rdata <= '0;
    end else begin
      latchC <= next_latchC;
      dirC <= next_dirC;
      latchD <= next_latchD;
      dirD <= next_dirD;
      dirE <= next_dirE;
      config_ <= next_config_;
      ack <= next_ack;
      rdata <= next_rdata;
    end
  end

  // First port: default is latch data under the direction register
  assign capOnC = config_[BIT_CAPTURE_TWO_PIN_SELECT];

  always_comb begin
    cOut = latchC;
    cOe = ~dirC;
    // Capture unit two compare output, direction still from the register
    if (capOnC && periphReq.capOutEn) begin
      cOut[PIN_C_CAPTURE] = periphReq.capOut; // RL16
    end
    // I2C data is open drain: only a low is driven, the pull-up makes the high
    if (periphReq.serI2cMode) begin
      cOut[PIN_C_SERIAL_DATA_IN] = 1'b0; // RL9
      cOe[PIN_C_SERIAL_DATA_IN] = ~periphReq.serI2cDataOut; // RL15
    end
    if (periphReq.serSpiEnable && !dirC[PIN_C_SPI_OUT]) begin
      cOut[PIN_C_SPI_OUT] = periphReq.serSpiOut; // RL10
    end
    if (periphReq.usartSyncMaster) begin
      cOut[PIN_C_USART_TIMING] = periphReq.usartClkOut; // RL12
      cOe[PIN_C_USART_TIMING] = 1'b1; // RL15
    end else if (periphReq.usartSyncSlave) begin
      cOe[PIN_C_USART_TIMING] = 1'b0; // RL12
    end else if (periphReq.usartAsyncTx) begin
      // The driver still follows the direction bit, so software must clear it
      cOut[PIN_C_USART_TIMING] = periphReq.usartTxData; // RL11
    end
    if (periphReq.usartSyncTransmit) begin
      cOut[PIN_C_USART_DATA] = periphReq.usartSyncDataOut; // RL14
      cOe[PIN_C_USART_DATA] = 1'b1; // RL15
    end
  end

  // Second port: parallel slave and PWM outputs take the pins over
  assign pwmMulti = periphReq.pwmEnable && (periphReq.pwmMode != PWM_SINGLE);
  assign parallelActive = dirE[BIT_PARALLEL_SLAVE_ENABLE] & ~pwmMulti; // RL5 RL6

  genvar gi;
  generate
    for (gi = 0; gi < PORT_W; gi++) begin : g_second_port_pins
      logic pwmHere;
      logic pwmBit;
      if (gi == PIN_D_PWM_B) begin : g_b
        assign pwmHere = pwmMulti;
        assign pwmBit = periphReq.pwmB;
      end else if (gi == PIN_D_PWM_C || gi == PIN_D_PWM_D) begin : g_cd
        assign pwmHere = periphReq.pwmEnable && (periphReq.pwmMode != PWM_SINGLE)
                         && (periphReq.pwmMode != PWM_HALF_BRIDGE);
        assign pwmBit = (gi == PIN_D_PWM_C) ? periphReq.pwmC : periphReq.pwmD;
      end else begin : g_none
        assign pwmHere = 1'b0;
        assign pwmBit = 1'b0;
      end
      always_comb begin
        if (pwmHere) begin
          dOut[gi] = pwmBit; // RL7
          dOe[gi] = ~dirD[gi];
        end else if (parallelActive) begin
          // Slave port read data comes from the latch; direction bit is ignored
          dOut[gi] = latchD[gi]; // RL5
          dOe[gi] = periphReq.parallelReadDrive; // RL15
        end else begin
          dOut[gi] = latchD[gi]; // RL2
          dOe[gi] = ~dirD[gi]; // RL1
        end
      end
    end
  endgenerate

  // Pin levels back to peripherals; outputs are combinational from synced levels
  always_comb begin
    periphRet = '0;
    periphRet.serSpiIn = cSync[PIN_C_SERIAL_DATA_IN] & dirC[PIN_C_SERIAL_DATA_IN]; // RL8
    periphRet.serI2cDataIn = cSync[PIN_C_SERIAL_DATA_IN] | ~periphReq.serI2cMode; // RL9
    periphRet.usartRxIn = cSync[PIN_C_USART_DATA] | ~dirC[PIN_C_USART_DATA]; // RL13
    periphRet.usartClkIn = cSync[PIN_C_USART_TIMING] & periphReq.usartSyncSlave; // RL12
    periphRet.usartDataIn = cSync[PIN_C_USART_DATA] & dirC[PIN_C_USART_DATA]; // RL14
    periphRet.capInC = cSync[PIN_C_CAPTURE] & capOnC;
    periphRet.capInB = bSync & ~capOnC;
    periphRet.capOnAltPin = ~capOnC;
    periphRet.parallelActive = parallelActive;
    periphRet.dInputTtl = parallelActive; // RL5
  end

  assign portCOut = cOut;
  assign portCOe = cOe;
  assign portDOut = dOut;
  assign portDOe = dOe;
  // Alternate pin carries the compare output only when the unit is moved there
  assign altPortBBit3Out = periphReq.capOut;
  assign altPortBBit3Oe = ~capOnC & periphReq.capOutEn; // RL16

endmodule : bidir_port_with_overrides

// >>> src/dual_port_pkg.sv
// Package: register map, reset values and carrier types for the dual bidirectional port
package dual_port_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int PORT_W = 8;

  // Byte addresses of the registers
  localparam logic [7:0] OFS_C_PINS = 8'h00;
  localparam logic [7:0] OFS_C_LATCH = 8'h04;
  localparam logic [7:0] OFS_C_DIR = 8'h08;
  localparam logic [7:0] OFS_D_PINS = 8'h0c;
  localparam logic [7:0] OFS_D_LATCH = 8'h10;
  localparam logic [7:0] OFS_D_DIR = 8'h14;
  localparam logic [7:0] OFS_E_DIR = 8'h18;
  localparam logic [7:0] OFS_CONFIG = 8'h1c;

  // Field positions
  localparam int BIT_PARALLEL_SLAVE_ENABLE = 4;
  localparam int BIT_CAPTURE_TWO_PIN_SELECT = 0;
  localparam int PIN_C_CAPTURE = 1;
  localparam int PIN_C_SERIAL_DATA_IN = 4;
  localparam int PIN_C_SPI_OUT = 5;
  localparam int PIN_C_USART_TIMING = 6;
  localparam int PIN_C_USART_DATA = 7;
  localparam int PIN_D_PWM_B = 5;
  localparam int PIN_D_PWM_C = 6;
  localparam int PIN_D_PWM_D = 7;

  // Reset values
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_LATCH = 8'h00;
  localparam logic [7:0] RST_E_DIR = 8'h00;
  localparam logic [7:0] RST_CONFIG = 8'h01;

  // Enhanced PWM output modes
  typedef enum logic [1:0] {
    PWM_SINGLE = 2'b00,
    PWM_HALF_BRIDGE = 2'b01,
    PWM_FULL_FWD = 2'b10,
    PWM_FULL_REV = 2'b11
  } pwm_mode_t;

  // Requests from the on-chip peripherals that share the pins
  typedef struct packed {
    logic capOutEn;
    logic capOut;
    logic serI2cMode;
    logic serI2cDataOut;
    logic serSpiEnable;
    logic serSpiOut;
    logic usartAsyncTx;
    logic usartTxData;
    logic usartSyncMaster;
    logic usartSyncSlave;
    logic usartClkOut;
    logic usartSyncTransmit;
    logic usartSyncDataOut;
    logic usartRxEnable;
    pwm_mode_t pwmMode;
    logic pwmEnable;
    logic pwmB;
    logic pwmC;
    logic pwmD;
    logic parallelReadDrive;
  } periph_req_t;

  // Pin levels handed back to the peripherals
  typedef struct packed {
    logic serSpiIn;
    logic serI2cDataIn;
    logic usartRxIn;
    logic usartClkIn;
    logic usartDataIn;
    logic capInC;
    logic capInB;
    logic capOnAltPin;
    logic parallelActive;
    logic dInputTtl;
  } periph_ret_t;

endpackage : dual_port_pkg

// >>> tb/port_sva.sv
// Assertions on the dual port block's bus timing and pin overrides
`timescale 1ns/10ps
module port_sva
  import dual_port_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Register bus
  input wire logic [dual_port_pkg::ADDR_W-1:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [3:0] avsByteenable,
  input wire logic [dual_port_pkg::DATA_W-1:0] avsWritedata,
  input wire logic [dual_port_pkg::DATA_W-1:0] avsReaddata,
  input wire logic avsWaitrequest,
  // Peripherals and pins
  input wire dual_port_pkg::periph_req_t periphReq,
  input wire dual_port_pkg::periph_ret_t periphRet,
  input wire logic [dual_port_pkg::PORT_W-1:0] portCOut,
  input wire logic [dual_port_pkg::PORT_W-1:0] portCOe,
  input wire logic [dual_port_pkg::PORT_W-1:0] portDOe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence dir_d_write;
    avsWrite && !avsWaitrequest && avsByteenable[0] && avsAddress == OFS_D_DIR;
  endsequence
  sequence psp_idle;
    !periphRet.parallelActive;
  endsequence
  one_wait_a: assert property ((avsRead || avsWrite) && avsWaitrequest |=> !avsWaitrequest)
    else $error("bus answer late");
  idle_wait_a: assert property (!(avsRead || avsWrite) |-> !avsWaitrequest)
    else $error("wait while idle");
  rdata_high_a: assert property (avsRead && !avsWaitrequest |-> avsReaddata[31:8] == 24'h0)
    else $error("read data upper bits set");
  dir_d_a: assert property (dir_d_write ##1 psp_idle |-> portDOe == ~$past(avsWritedata[7:0]))
    else $error("second port enables differ from direction");
  psp_oe_a: assert property (periphRet.parallelActive |-> portDOe == {8{periphReq.parallelReadDrive}})
    else $error("slave port enable wrong");
  pwm_off_a: assert property (periphReq.pwmEnable && periphReq.pwmMode != PWM_SINGLE |-> psp_idle)
    else $error("slave port left on in multi output mode");
  clk_master_a: assert property (periphReq.usartSyncMaster |-> portCOe[6] && portCOut[6] == periphReq.usartClkOut)
    else $error("sync clock not on pin 6");
  sync_tx_a: assert property (periphReq.usartSyncTransmit |-> portCOe[7] && portCOut[7] == periphReq.usartSyncDataOut)
    else $error("sync data not on pin 7");
  i2c_data_a: assert property (periphReq.serI2cMode |-> !portCOut[4] && portCOe[4] == !periphReq.serI2cDataOut)
    else $error("i2c data pin wrong");
endmodule : port_sva

bind bidir_port_with_overrides port_sva port_sva_i (.clk(clk), .nrst(nrst), .avsAddress(avsAddress),
  .avsRead(avsRead), .avsWrite(avsWrite), .avsByteenable(avsByteenable), .avsWritedata(avsWritedata),
  .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .periphReq(periphReq),
  .periphRet(periphRet), .portCOut(portCOut), .portCOe(portCOe), .portDOe(portDOe));

// >>> tb/pin_board.sv
// Board model: outside circuitry on both ports
`timescale 1ns/10ps
module pin_board (
  // Block side
  input wire logic [15:0] drv,
  input wire logic [15:0] oe,
  // Outside drivers
  input wire logic [15:0] ext,
  output logic [15:0] lvl
);
  // A released pin follows the outside driver, never the block's stale value
  assign lvl = (drv & oe) | (ext & ~oe);
endmodule : pin_board

// >>> tb/bidir_port_with_overrides_test.sv
// Self-checking bench for the dual port block
`timescale 1ns/10ps
module bidir_port_with_overrides_test;
  import dual_port_pkg::*;
  logic clk = 0, nrst = 0, avsRead = 0, avsWrite = 0, altIn = 0, avsWaitrequest, altOut, altOe;
  logic [7:0] avsAddress = 0, q, cPin, dPin, cOut, cOe, dOut, dOe;
  logic [7:0] extC = 8'h00, extD = 8'h00;
  logic [3:0] be = 4'hf;
  logic [31:0] avsWritedata = 0, avsReaddata;
  periph_req_t req = '0;
  periph_ret_t ret;
  int n_errors = 0, comparisons = 0;
  always #10 clk = ~clk;
  bidir_port_with_overrides bidir_port_with_overrides_i (.clk(clk), .nrst(nrst), .avsAddress(avsAddress),
    .avsRead(avsRead), .avsWrite(avsWrite), .avsByteenable(be), .avsWritedata(avsWritedata),
    .avsReaddata(avsReaddata), .avsWaitrequest(avsWaitrequest), .periphReq(req), .periphRet(ret),
    .portCIn(cPin), .portCOut(cOut), .portCOe(cOe), .portDIn(dPin), .portDOut(dOut), .portDOe(dOe),
    .altPortBBit3In(altIn), .altPortBBit3Out(altOut), .altPortBBit3Oe(altOe));
  pin_board pin_board_i (.drv({dOut, cOut}), .oe({dOe, cOe}), .ext({extD, extC}), .lvl({dPin, cPin}));
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [7:0] e, g);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One bus access; the request holds until waitrequest is sampled low at a rising edge
  task automatic acc(input logic w, input logic [7:0] a, d);
    @(posedge clk);
    avsAddress <= a;
    avsWrite <= w;
    avsRead <= !w;
    avsWritedata <= {24'h0, d};
    do @(posedge clk); while (avsWaitrequest !== 1'b0);
    q = avsReaddata[7:0];
    avsWrite <= 0;
    avsRead <= 0;
  endtask : acc
  task automatic rd(input logic [7:0] a, e, input string nm);
    acc(0, a, 8'h00);
    chk(nm, e, q);
  endtask : rd
  initial begin
    #200us;
    n_errors++;
    summarize();
  end
  initial begin
    repeat (3) @(posedge clk);
    nrst <= 1;
    @(negedge clk);
    chk("d oe", 8'h00, dOe);
    rd(OFS_D_DIR, 8'hff, "d dir");
    rd(OFS_CONFIG, 8'h01, "config");
    rd(8'h40, 8'h00, "unmapped");
    $display("reset test done");
    extD <= 8'h3c;
    acc(1, OFS_D_PINS, 8'ha5);
    acc(1, OFS_D_DIR, 8'hf0);
    @(negedge clk);
    chk("d oe", 8'h0f, dOe);
    chk("d out", 8'h05, dOut & 8'h0f);
    repeat (4) @(posedge clk);
    rd(OFS_D_LATCH, 8'ha5, "d latch");
    rd(OFS_D_PINS, 8'h35, "d pins");
    be <= 4'he;
    acc(1, OFS_D_LATCH, 8'h00);
    be <= 4'hf;
    rd(OFS_D_LATCH, 8'ha5, "masked write");
    $display("second port test done");
    acc(1, OFS_C_PINS, 8'h7c);
    rd(OFS_C_LATCH, 8'h7c, "c latch");
    acc(1, OFS_C_DIR, 8'hd0);
    extC <= 8'h10;
    req.usartSyncMaster <= 1;
    req.usartClkOut <= 1;
    req.serSpiEnable <= 1;
    req.capOutEn <= 1;
    req.capOut <= 1;
    rd(OFS_C_DIR, 8'hd0, "c dir");
    repeat (4) @(negedge clk);
    chk("c ovr", 8'hb6, {ret.serSpiIn, ret.usartRxIn, cOe[6], cOut[6], cOut[5], cOut[1], 2'b10});
    @(posedge clk);
    req.usartSyncMaster <= 0;
    req.usartAsyncTx <= 1;
    req.usartSyncTransmit <= 1;
    req.usartSyncDataOut <= 1;
    req.serI2cMode <= 1;
    acc(1, OFS_C_DIR, 8'h90);
    acc(1, OFS_CONFIG, 8'h00);
    @(negedge clk);
    chk("c sync", 8'hb8, {cOe[6], cOut[6], cOe[7], cOut[7], cOe[4], cOut[4], cOut[1], 1'b0});
    chk("alt pin", 8'h03, {5'h0, ret.serI2cDataIn, altOe, altOut});
    $display("first port test done");
    acc(1, OFS_E_DIR, 8'h10);
    acc(1, OFS_D_DIR, 8'h00);
    req.pwmEnable <= 1;
    req.pwmC <= 1;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk);
      req.pwmMode <= pwm_mode_t'(m);
      @(negedge clk);
      chk("psp", (m == 0) ? 8'h03 : 8'h00, {6'h0, ret.parallelActive, ret.dInputTtl});
    end
    chk("pwm pins", 8'h40, dOut & 8'he0);
    $display("slave port test done");
    summarize();
  end
endmodule : bidir_port_with_overrides_test
